// ---- verilog/memmap_pkg.sv ----
package memmap_pkg;
	// ----------------------------------------
	// data space layout
	// ----------------------------------------
	localparam int ADDR_W = 16;
	localparam logic [15:0] REGFILE_BASE = 16'h0000;
	localparam logic [15:0] REGFILE_LAST = 16'h001f;
	localparam logic [15:0] STDIO_BASE = 16'h0020;
	localparam logic [15:0] STDIO_LAST = 16'h005f;
	localparam logic [15:0] EXTIO_BASE = 16'h0060;
	localparam logic [15:0] EXTIO_LAST = 16'h00ff;
	localparam logic [15:0] SRAM_BASE = 16'h0100;
	localparam logic [15:0] SRAM_LAST = 16'h08ff;
	localparam int SRAM_BYTES = 2048;
	localparam int NUM_WREGS = 32;
	localparam int NUM_STDIO = 64;
	localparam logic [5:0] DISP_MAX = 6'h3f;
	// pointer pairs live in working registers 26..31
	localparam logic [4:0] PTR_FIRST_LO = 5'h1a;
	localparam logic [4:0] PTR_SECOND_LO = 5'h1c;
	localparam logic [4:0] PTR_THIRD_LO = 5'h1e;
	localparam logic [15:0] PTR_RESET = 16'h0000;
	// ----------------------------------------
	// program memory and eeprom
	// ----------------------------------------
	localparam int PROG_COUNT_W = 14;
	localparam int PMEM_WORDS = 16384;
	localparam logic [13:0] BOOT_START_DEFAULT = 14'h3800;
	localparam int EE_ADDR_W = 10;
	localparam int EE_BYTES = 1024;
	localparam int EE_WRITE_NS = 3400000;
	localparam int CLK_NS = 10;
	localparam int EE_WRITE_CYCLES = (EE_WRITE_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [1:0] SRAM_CYCLES = 2'h2;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [2:0] {
		MODE_DIRECT = 3'b000,
		MODE_INDIRECT = 3'b001,
		MODE_DISP = 3'b010,
		MODE_PREDEC = 3'b011,
		MODE_POSTINC = 3'b100
	} mode_type;

	typedef enum logic [1:0] {
		PTR_FIRST = 2'b00,
		PTR_SECOND = 2'b01,
		PTR_THIRD = 2'b10
	} ptr_sel_type;

	typedef enum logic [2:0] {
		REGION_WREG = 3'b000,
		REGION_STDIO = 3'b001,
		REGION_EXTIO = 3'b010,
		REGION_SRAM = 3'b011,
		REGION_NONE = 3'b100
	} region_type;

	typedef struct packed {
		logic valid;
		logic write;
		logic short_io;
		mode_type mode;
		ptr_sel_type ptr;
		logic [5:0] disp;
		logic [15:0] direct_addr;
		logic [7:0] wdata;
	} mem_req_type;

	typedef struct packed {
		logic valid;
		logic refused;
		logic [7:0] rdata;
	} mem_rsp_type;
endpackage

// ---- verilog/region_decode.sv ----
`timescale 1ns/1ns
// ----------------------------------------
// address to region decoder
// ----------------------------------------
module region_decode (
	// address in
	input wire logic [15:0] addr,
	// decode out
	output memmap_pkg::region_type region,
	output logic [15:0] offset
);
	// plain comparisons keep the map in one place
	always_comb begin
		offset = 16'h0000;
		if (addr <= memmap_pkg::REGFILE_LAST) begin
			region = memmap_pkg::REGION_WREG;
			offset = addr;
		end else if (addr <= memmap_pkg::STDIO_LAST) begin
			region = memmap_pkg::REGION_STDIO;
			offset = addr - memmap_pkg::STDIO_BASE;
		end else if (addr <= memmap_pkg::EXTIO_LAST) begin
			region = memmap_pkg::REGION_EXTIO;
			offset = addr - memmap_pkg::EXTIO_BASE;
		end else if (addr <= memmap_pkg::SRAM_LAST) begin
			region = memmap_pkg::REGION_SRAM;
			offset = addr - memmap_pkg::SRAM_BASE;
		end else begin
			region = memmap_pkg::REGION_NONE;
		end
	end
endmodule

// ---- verilog/eeprom_write_timer.sv ----
`timescale 1ns/1ns
// ----------------------------------------
// eeprom write timer, survives reset
// ----------------------------------------
module eeprom_write_timer #(
	parameter int WRITE_CYCLES = memmap_pkg::EE_WRITE_CYCLES
) (
	// clock and power-on reset only
	input wire logic clk,
	input wire logic npor,
	input wire logic ce,
	// control
	input wire logic start,
	output logic busy
);
	logic [21:0] count_reg;
	// chip reset is deliberately not wired here so a write finishes
	always_ff @(posedge clk or negedge npor) begin
		if (!npor) begin
			count_reg <= 22'h000000;
		end else if (ce) begin
			if (start && count_reg == 22'h000000) begin
				count_reg <= 22'(WRITE_CYCLES);
			end else if (count_reg != 22'h000000) begin
				count_reg <= count_reg - 22'h000001;
			end
		end
	end
	assign busy = (count_reg != 22'h000000);
endmodule

// ---- verilog/data_memory_map_decoder.sv ----
`timescale 1ns/1ns
// Notes on behaviour
// - lowest 2304 addresses split into four consecutive regions.
// - 0x0000-0x001F select the 32 working registers.
// - 0x0020-0x005F select the 64 standard I/O registers.
// - 0x0060-0x00FF select the 160 extended I/O registers.
// - short I/O opcodes reach only 64 locations, never extended I/O.
// - direct, indirect, displacement, pre-decrement, post-increment modes supported.
// - registers 26..31 pair up as three pointer registers.
// - direct addressing reaches the whole data space.
// - displacement up to 63 on second or third pointer only.
// - pre-decrement and post-increment write updated pointer back.
// - all modes reach all four regions uniformly.
// - SRAM access completes in two core clock cycles.
// - program memory 16K words of 16 bits, 14-bit program counter.
// - program memory split into boot and application sections.
// - EEPROM is a separate 1 KB byte-wide space.
// - EEPROM write continues through power-down; clock keeps running.
// - reset during EEPROM write still lets the write finish.
// - EEPROM addressed linearly by 10 bits, 0 to 1023.
module data_memory_map_decoder #(
	parameter int SRAM_DEPTH = memmap_pkg::SRAM_BYTES,
	parameter int EE_WRITE_CYCLES = memmap_pkg::EE_WRITE_CYCLES,
	parameter logic [13:0] BOOT_START = memmap_pkg::BOOT_START_DEFAULT
) (
	// clock and resets
	input wire logic clk,
	input wire logic nrst,
	input wire logic npor,
	input wire logic ce,
	// load/store request and answer
	input memmap_pkg::mem_req_type req,
	output memmap_pkg::mem_rsp_type rsp,
	output logic busy,
	// i/o register port toward peripherals
	output logic io_strobe,
	output logic io_write,
	output logic io_ext,
	output logic [7:0] io_addr,
	output logic [7:0] io_wdata,
	input wire logic [7:0] io_rdata,
	// program memory section check
	input wire logic [13:0] program_counter,
	output logic in_boot_section,
	// eeprom control
	input wire logic ee_start,
	input wire logic [9:0] ee_addr,
	input wire logic [7:0] ee_wdata,
	input wire logic sleep_req,
	output logic ee_busy,
	output logic [7:0] ee_rdata,
	output logic powered_down
);
	// ----------------------------------------
	// storage
	// ----------------------------------------
	logic [7:0] wreg_mem [memmap_pkg::NUM_WREGS];
	logic [7:0] sram_mem [SRAM_DEPTH];
	logic [7:0] ee_mem [memmap_pkg::EE_BYTES];

	typedef enum logic [1:0] {
		IDLE_S = 2'b00,
		SRAM2_S = 2'b01
	} state_type;
	state_type state_reg;

	// ----------------------------------------
	// address generation
	// ----------------------------------------
	logic [4:0] ptr_lo;
	logic [15:0] ptr_val;
	logic [15:0] eff_addr;
	logic [15:0] ptr_new;
	logic ptr_update;
	logic mode_ok;

	// pointer pairs sit in the top six working registers
	always_comb begin
		case (req.ptr)
			memmap_pkg::PTR_SECOND: ptr_lo = memmap_pkg::PTR_SECOND_LO;
			memmap_pkg::PTR_THIRD: ptr_lo = memmap_pkg::PTR_THIRD_LO;
			default: ptr_lo = memmap_pkg::PTR_FIRST_LO;
		endcase
	end
	assign ptr_val = {wreg_mem[ptr_lo + 5'h01], wreg_mem[ptr_lo]};

	// effective address per addressing mode
	always_comb begin
		eff_addr = ptr_val;
		ptr_new = ptr_val;
		ptr_update = 1'b0;
		mode_ok = 1'b1;
		case (req.mode)
			memmap_pkg::MODE_DIRECT: begin
				eff_addr = req.direct_addr;
			end
			memmap_pkg::MODE_INDIRECT: begin
				eff_addr = ptr_val;
			end
			memmap_pkg::MODE_DISP: begin
				eff_addr = ptr_val + {10'h000, req.disp};
				mode_ok = (req.ptr != memmap_pkg::PTR_FIRST);
			end
			memmap_pkg::MODE_PREDEC: begin
				ptr_new = ptr_val - 16'h0001;
				eff_addr = ptr_new;
				ptr_update = 1'b1;
			end
			memmap_pkg::MODE_POSTINC: begin
				ptr_new = ptr_val + 16'h0001;
				eff_addr = ptr_val;
				ptr_update = 1'b1;
			end
			default: mode_ok = 1'b0;
		endcase
		// short i/o opcodes carry a 6-bit port number mapped past the file
		if (req.short_io) begin
			eff_addr = memmap_pkg::STDIO_BASE + {10'h000, req.direct_addr[5:0]};
			ptr_update = 1'b0;
			mode_ok = 1'b1;
		end
	end

	// ----------------------------------------
	// region decode, shared by every mode
	// ----------------------------------------
	memmap_pkg::region_type region;
	logic [15:0] offset;

	region_decode u_decode (
		.addr(eff_addr),
		.region(region),
		.offset(offset)
	);

	logic take;
	assign take = ce && req.valid && state_reg == IDLE_S;

	// ----------------------------------------
	// access sequencer
	// ----------------------------------------
	logic [10:0] sram_idx_reg;
	logic sram_wr_reg;
	logic [7:0] sram_wdata_reg;

	// sram takes a second cycle; others answer next edge
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= IDLE_S;
			sram_idx_reg <= 11'h000;
			sram_wr_reg <= 1'b0;
			sram_wdata_reg <= 8'h00;
		end else if (ce) begin
			case (state_reg)
				IDLE_S: begin
					if (take && mode_ok && region == memmap_pkg::REGION_SRAM) begin
						state_reg <= SRAM2_S;
						sram_idx_reg <= offset[10:0];
						sram_wr_reg <= req.write;
						sram_wdata_reg <= req.wdata;
					end
				end
				SRAM2_S: state_reg <= IDLE_S;
				default: state_reg <= IDLE_S;
			endcase
		end
	end

	// sram array, written in the second cycle
	always_ff @(posedge clk) begin
		if (ce && state_reg == SRAM2_S && sram_wr_reg) begin
			sram_mem[sram_idx_reg] <= sram_wdata_reg;
		end
	end

	// working registers and pointer writeback
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < memmap_pkg::NUM_WREGS; i++) begin
				wreg_mem[i] <= 8'h00;
			end
		end else if (ce && take && mode_ok) begin
			if (req.write && region == memmap_pkg::REGION_WREG) begin
				wreg_mem[offset[4:0]] <= req.wdata;
			end
			// pointer update wins over a store into the pointer itself
			if (ptr_update) begin
				wreg_mem[ptr_lo] <= ptr_new[7:0];
				wreg_mem[ptr_lo + 5'h01] <= ptr_new[15:8];
			end
		end
	end

	// ----------------------------------------
	// responses and i/o port
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rsp <= '0;
			busy <= 1'b0;
			io_strobe <= 1'b0;
			io_write <= 1'b0;
			io_ext <= 1'b0;
			io_addr <= 8'h00;
			io_wdata <= 8'h00;
		end else if (ce) begin
			rsp.valid <= 1'b0;
			rsp.refused <= 1'b0;
			io_strobe <= 1'b0;
			busy <= take && mode_ok && region == memmap_pkg::REGION_SRAM;
			if (state_reg == SRAM2_S) begin
				rsp.valid <= 1'b1;
				rsp.rdata <= sram_wr_reg ? 8'h00 : sram_mem[sram_idx_reg];
			end else if (take) begin
				if (!mode_ok) begin
					rsp.valid <= 1'b1;
					rsp.refused <= 1'b1;
				end else if (region == memmap_pkg::REGION_WREG) begin
					rsp.valid <= 1'b1;
					rsp.rdata <= wreg_mem[offset[4:0]];
				end else if (region == memmap_pkg::REGION_STDIO ||
						region == memmap_pkg::REGION_EXTIO) begin
					// io read data reaches rdata from peripherals one cycle after the answer cycle
					rsp.valid <= 1'b1;
					io_strobe <= 1'b1;
					io_write <= req.write;
					io_ext <= (region == memmap_pkg::REGION_EXTIO);
					io_addr <= offset[7:0];
					io_wdata <= req.wdata;
				end else if (region == memmap_pkg::REGION_NONE) begin
					rsp.valid <= 1'b1;
					rsp.rdata <= 8'h00;
				end
			end
			if (io_strobe && !io_write) begin
				rsp.rdata <= io_rdata;
			end
		end
	end

	// ----------------------------------------
	// program memory sections
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			in_boot_section <= 1'b0;
		end else if (ce) begin
			in_boot_section <= (program_counter >= BOOT_START);
		end
	end

	// ----------------------------------------
	// eeprom
	// ----------------------------------------
	logic ee_timer_busy;
	logic ee_go;
	assign ee_go = ce && ee_start && !ee_timer_busy;

	eeprom_write_timer #(
		.WRITE_CYCLES(EE_WRITE_CYCLES)
	) u_ee_timer (
		.clk(clk),
		.npor(npor),
		.ce(ce),
		.start(ee_start),
		.busy(ee_timer_busy)
	);

	// array write is kept off nrst so a reset cannot abort it
	always_ff @(posedge clk) begin
		if (ee_go) begin
			ee_mem[ee_addr] <= ee_wdata;
		end
	end

	// a sleep that met a running write stays awake until sleep is dropped,
	// since the clock is left running once that write completes
	logic sleep_blocked_reg;
	always_ff @(posedge clk or negedge npor) begin
		if (!npor) begin
			sleep_blocked_reg <= 1'b0;
		end else if (ce) begin
			if (sleep_req && (ee_timer_busy || ee_go)) begin
				sleep_blocked_reg <= 1'b1;
			end else if (!sleep_req) begin
				sleep_blocked_reg <= 1'b0;
			end
		end
	end

	// read port and status, on power-on reset only
	always_ff @(posedge clk or negedge npor) begin
		if (!npor) begin
			ee_busy <= 1'b0;
			ee_rdata <= 8'h00;
			powered_down <= 1'b0;
		end else if (ce) begin
			ee_busy <= ee_timer_busy || ee_go;
			ee_rdata <= ee_mem[ee_addr];
			// clock is held alive while a write runs in sleep
			powered_down <= sleep_req && !ee_timer_busy && !ee_go
				&& !sleep_blocked_reg;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	AST_SRAM_TWO_CYCLES: assert property (@(posedge clk) disable iff (!nrst)
		(ce && take && mode_ok && region == memmap_pkg::REGION_SRAM) ##1 ce
			|=> rsp.valid)
		else $error("sram answer not after two cycles");
	AST_REG_ONE_CYCLE: assert property (@(posedge clk) disable iff (!nrst)
		(take && mode_ok && region == memmap_pkg::REGION_WREG) |=> rsp.valid)
		else $error("register answer late");
	AST_SHORT_IO_STD: assert property (@(posedge clk) disable iff (!nrst)
		(take && req.short_io) |=> (io_strobe && !io_ext))
		else $error("short io reached extended space");
	AST_DISP_FIRST_REFUSED: assert property (@(posedge clk) disable iff (!nrst)
		(take && !req.short_io && req.mode == memmap_pkg::MODE_DISP
			&& req.ptr == memmap_pkg::PTR_FIRST) |=> rsp.refused)
		else $error("first pointer displacement not refused");
	AST_POSTINC_WB: assert property (@(posedge clk) disable iff (!nrst)
		(take && !req.short_io && req.mode == memmap_pkg::MODE_POSTINC)
			|=> ({wreg_mem[$past(ptr_lo) + 5'h01], wreg_mem[$past(ptr_lo)]}
				== $past(ptr_val) + 16'h0001))
		else $error("post-increment not written back");
	AST_EXT_FLAG: assert property (@(posedge clk) disable iff (!nrst)
		(take && mode_ok && region == memmap_pkg::REGION_EXTIO) |=> (io_strobe && io_ext))
		else $error("extended io not flagged");
	AST_NO_SRAM_BEYOND: assert property (@(posedge clk) disable iff (!nrst)
		(take && region == memmap_pkg::REGION_NONE) |=> (state_reg == IDLE_S && !io_strobe))
		else $error("out of range access acted");
	AST_EE_NO_POWERDOWN: assert property (@(posedge clk) disable iff (!npor)
		(ce && ee_timer_busy) |=> !powered_down)
		else $error("powered down during eeprom write");
	AST_SRAM_BUSY: assert property (@(posedge clk) disable iff (!nrst)
		(take && mode_ok && region == memmap_pkg::REGION_SRAM)
			|=> (busy && state_reg == SRAM2_S))
		else $error("sram second cycle not marked busy");
	AST_STD_NOT_EXT: assert property (@(posedge clk) disable iff (!nrst)
		(take && mode_ok && region == memmap_pkg::REGION_STDIO) |=> (io_strobe && !io_ext))
		else $error("standard io flagged as extended");
	AST_PREDEC_WB: assert property (@(posedge clk) disable iff (!nrst)
		(take && !req.short_io && req.mode == memmap_pkg::MODE_PREDEC)
			|=> ({wreg_mem[$past(ptr_lo) + 5'h01], wreg_mem[$past(ptr_lo)]}
				== $past(ptr_val) - 16'h0001))
		else $error("pre-decrement not written back");
	AST_EE_RESET_KEEPS: assert property (@(posedge clk) disable iff (!npor)
		(ce && !nrst && ee_timer_busy) |=> ee_busy)
		else $error("chip reset cut an eeprom write");
	AST_EE_SLEEP_BLOCKED: assert property (@(posedge clk) disable iff (!npor)
		(ce && sleep_req && sleep_blocked_reg) |=> !powered_down)
		else $error("powered down after a write met in sleep");
endmodule

// ---- dv/io_periph_model.sv ----
`timescale 1ns/1ns
// ----------------------------------------
// peripheral register responder
// ----------------------------------------
module io_periph_model (
	// clock
	input wire logic clk,
	// strobe side
	input wire logic io_strobe,
	input wire logic io_ext,
	input wire logic [7:0] io_addr,
	// read data back
	output logic [7:0] io_rdata
);
	logic [7:0] last_reg = 8'h00;

	// answer only while strobed; otherwise the inverse of the last value,
	// so a decoder that samples late never sees a stale match
	always_comb begin
		io_rdata = io_strobe ? (io_addr ^ {io_ext, 7'h5a}) : ~last_reg;
	end

	// remember what was last on the lines
	always_ff @(posedge clk) begin
		last_reg <= io_rdata;
	end
endmodule

// ---- dv/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic npor = 1'b0;
	logic ce = 1'b1;
	memmap_pkg::mem_req_type req = '0;
	memmap_pkg::mem_rsp_type rsp;
	logic busy, io_strobe, io_write, io_ext, in_boot_section, ee_busy, powered_down;
	logic [7:0] io_addr, io_wdata, io_rdata, ee_rdata, rd, io_a, io_wd;
	logic [13:0] program_counter = 14'h0000;
	logic ee_start = 1'b0;
	logic [9:0] ee_addr = 10'h000;
	logic [7:0] ee_wdata = 8'h00;
	logic sleep_req = 1'b0;
	logic refd, saw_io, saw_busy, io_x, io_w;
	int fail_count = 0;
	int tests_run = 0;
	int lat;

	// short write time keeps the eeprom test brief
	data_memory_map_decoder #(.EE_WRITE_CYCLES(8)) data_memory_map_decoder_i (
		.clk(clk), .nrst(nrst), .npor(npor), .ce(ce), .req(req), .rsp(rsp),
		.busy(busy), .io_strobe(io_strobe), .io_write(io_write), .io_ext(io_ext),
		.io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
		.program_counter(program_counter), .in_boot_section(in_boot_section),
		.ee_start(ee_start), .ee_addr(ee_addr), .ee_wdata(ee_wdata),
		.sleep_req(sleep_req), .ee_busy(ee_busy), .ee_rdata(ee_rdata),
		.powered_down(powered_down)
	);
	io_periph_model io_periph_model_i (
		.clk(clk), .io_strobe(io_strobe), .io_ext(io_ext), .io_addr(io_addr),
		.io_rdata(io_rdata)
	);

	initial begin
		forever #5 clk = ~clk;
	end

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up;
		$display("compares %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// one request, held for its taking edge only; rdata read a cycle after valid
	task automatic acc(input logic w, input logic s, input memmap_pkg::mode_type m,
			input memmap_pkg::ptr_sel_type p, input logic [5:0] d,
			input logic [15:0] a, input logic [7:0] wd);
		lat = 0;
		saw_io = 1'b0;
		saw_busy = 1'b0;
		@(posedge clk);
		req <= '{1'b1, w, s, m, p, d, a, wd};
		@(posedge clk);
		req.valid <= 1'b0;
		do begin
			@(negedge clk);
			lat++;
			if (busy === 1'b1) saw_busy = 1'b1;
			if (io_strobe === 1'b1) begin
				saw_io = 1'b1;
				io_a = io_addr;
				io_x = io_ext;
				io_w = io_write;
				io_wd = io_wdata;
			end
		end while (rsp.valid !== 1'b1 && lat < 6);
		if (lat >= 6) begin
			$display("ERROR t=%0t no answer", $time);
			fail_count++;
			wrap_up();
		end
		refd = rsp.refused;
		@(negedge clk);
		rd = rsp.rdata;
	endtask

	task automatic dir(input logic w, input logic [15:0] a, input logic [7:0] wd);
		acc(w, 1'b0, memmap_pkg::MODE_DIRECT, memmap_pkg::PTR_FIRST, 6'h00, a, wd);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs;
		dir(1'b1, 16'h0005, 8'ha5);
		chk(lat, 1);
		dir(1'b0, 16'h0005, 8'h00);
		chk(rd, 8'ha5);
		chk(saw_io, 0);
		$display("regs test done");
	endtask

	task automatic t_sram;
		for (int i = 0; i < 2; i++) begin
			dir(1'b1, i ? 16'h08ff : 16'h0100, 8'h11 + i[7:0]);
		end
		for (int i = 0; i < 2; i++) begin
			dir(1'b0, i ? 16'h08ff : 16'h0100, 8'h00);
			chk(lat, memmap_pkg::SRAM_CYCLES);
			chk(saw_busy, 1);
			chk(rd, 8'h11 + i[7:0]);
		end
		$display("sram test done");
	endtask

	task automatic t_io;
		logic [15:0] ad [4] = '{16'h0020, 16'h005f, 16'h0060, 16'h00ff};
		logic e;
		logic [7:0] o;
		for (int i = 0; i < 4; i++) begin
			e = ad[i] >= 16'h0060;
			o = 8'(ad[i] - (e ? 16'h0060 : 16'h0020));
			dir(1'b0, ad[i], 8'h00);
			chk(saw_io, 1);
			chk(io_x, e);
			chk(io_a, o);
			chk(io_w, 0);
			chk(rd, o ^ {e, 7'h5a});
		end
		// short form folds the extended address into standard space
		acc(1'b0, 1'b1, memmap_pkg::MODE_DIRECT, memmap_pkg::PTR_FIRST, 6'h00, 16'h00ff, 8'h00);
		chk(io_x, 0);
		chk(io_a, 8'h3f);
		// a store into extended space reaches the port with its data
		dir(1'b1, 16'h00a0, 8'h6b);
		chk(io_w, 1);
		chk(io_wd, 8'h6b);
		chk(io_a, 8'h40);
		$display("io test done");
	endtask

	task automatic t_unmapped;
		dir(1'b1, 16'h0900, 8'h5c);
		dir(1'b0, 16'h0900, 8'h00);
		chk(rd, 8'h00);
		chk(saw_io, 0);
		dir(1'b0, 16'h0100, 8'h00);
		chk(rd, 8'h11);
		$display("unmapped test done");
	endtask

	task automatic t_ptr;
		dir(1'b1, 16'h001f, 8'h01);
		dir(1'b1, 16'h001d, 8'h01);
		dir(1'b1, 16'h001a, 8'h05);
		acc(1'b1, 1'b0, memmap_pkg::MODE_POSTINC, memmap_pkg::PTR_THIRD, 6'h00, 16'h0, 8'h99);
		chk(lat, 2);
		dir(1'b0, 16'h001e, 8'h00);
		chk(rd, 8'h01);
		acc(1'b0, 1'b0, memmap_pkg::MODE_PREDEC, memmap_pkg::PTR_THIRD, 6'h00, 16'h0, 8'h00);
		chk(rd, 8'h99);
		dir(1'b0, 16'h001e, 8'h00);
		chk(rd, 8'h00);
		dir(1'b1, 16'h013f, 8'h3f);
		acc(1'b0, 1'b0, memmap_pkg::MODE_DISP, memmap_pkg::PTR_SECOND, 6'h3f, 16'h0, 8'h00);
		chk(rd, 8'h3f);
		chk(refd, 0);
		acc(1'b0, 1'b0, memmap_pkg::MODE_INDIRECT, memmap_pkg::PTR_FIRST, 6'h00, 16'h0, 8'h00);
		chk(rd, 8'ha5);
		acc(1'b0, 1'b0, memmap_pkg::MODE_DISP, memmap_pkg::PTR_FIRST, 6'h01, 16'h0, 8'h00);
		chk(refd, 1);
		$display("pointer test done");
	endtask

	task automatic t_boot;
		logic [13:0] pcs [3] = '{14'h37ff, 14'h3800, 14'h3fff};
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			program_counter <= pcs[i];
			repeat (2) @(negedge clk);
			chk(in_boot_section, pcs[i] >= 14'h3800);
		end
		$display("boot test done");
	endtask

	task automatic t_ee;
		int n;
		@(posedge clk);
		ee_addr <= 10'h3ff;
		ee_wdata <= 8'h3c;
		ee_start <= 1'b1;
		@(posedge clk);
		ee_start <= 1'b0;
		// sleep asked while the write still runs
		sleep_req <= 1'b1;
		repeat (2) @(negedge clk);
		chk(ee_busy, 1);
		chk(powered_down, 0);
		@(posedge clk);
		nrst <= 1'b0;
		@(posedge clk);
		nrst <= 1'b1;
		@(negedge clk);
		chk(ee_busy, 1);
		n = 0;
		while (ee_busy !== 1'b0 && n < 20) begin
			@(negedge clk);
			n++;
		end
		chk(n < 20, 1);
		repeat (2) @(negedge clk);
		chk(powered_down, 0);
		chk(ee_rdata, 8'h3c);
		// sleep asked again once idle does power down
		@(posedge clk);
		sleep_req <= 1'b0;
		@(posedge clk);
		sleep_req <= 1'b1;
		repeat (2) @(negedge clk);
		chk(powered_down, 1);
		$display("eeprom test done");
	endtask

	initial begin
		repeat (2) @(posedge clk);
		npor <= 1'b1;
		nrst <= 1'b1;
		t_regs();
		t_sram();
		t_io();
		t_unmapped();
		t_ptr();
		t_boot();
		t_ee();
		wrap_up();
	end
endmodule
